/* verilog/dpf_pkg.sv */
package dpf_pkg;

   // ***********************************************
   // Register map (byte addresses, 32-bit words)
   // ***********************************************
   localparam logic [7:0] REG_CMD      = 8'h00;  // Command, write starts
   localparam logic [7:0] REG_STATUS   = 8'h04;  // Busy and last error
   localparam logic [7:0] REG_BITS_LO  = 8'h08;  // Bit points 0..31
   localparam logic [7:0] REG_BITS_HI  = 8'h0C;  // Bit points 32..63
   localparam logic [7:0] REG_DATA_IN  = 8'h10;  // Word source operand
   localparam logic [7:0] REG_RESULT   = 8'h14;  // Packed or loaded word
   localparam logic [7:0] REG_FP_INFO  = 8'h18;  // Real operand fields
   localparam logic [7:0] REG_FRAC_LO  = 8'h1C;  // Fraction bits 31..0
   localparam logic [7:0] REG_FRAC_HI  = 8'h20;  // Fraction bits 51..32
   localparam logic [7:0] REG_IRQ_STAT = 8'h24;  // Sticky events, read clears
   localparam logic [7:0] REG_IRQ_MASK = 8'h28;  // Event enables

   // ***********************************************
   // Field positions and reset values
   // ***********************************************
   localparam int CMD_OP_LSB    = 0;   // op, 3 bits
   localparam int CMD_DBL_BIT   = 3;   // double precision
   localparam int CMD_KIND_LSB  = 4;   // storage kind, 2 bits
   localparam int CMD_DIG_LSB   = 8;   // digit count, 4 bits
   localparam int CMD_START_LSB = 16;  // start bit point, 5 bits
   localparam int CMD_ADDR_LSB  = 24;  // storage point, 4 bits
   localparam int ST_BUSY_BIT   = 0;
   localparam int ST_ERR_BIT    = 1;
   localparam int EV_DONE_BIT   = 0;
   localparam int EV_ERR_BIT    = 1;
   localparam int FI_POWER_LSB  = 16;
   localparam logic [31:0] REG_RST    = 32'h0000_0000;
   localparam logic [1:0]  EV_NONE    = 2'h0;

   // ***********************************************
   // Operand formats
   // ***********************************************
   localparam int DIGIT_BITS = 4;   // Points per digit
   localparam int MAX_DIGITS = 8;   // 32 points
   localparam int SP_EXP_W   = 8;
   localparam int SP_FRAC_W  = 23;
   localparam int DP_EXP_W   = 11;
   localparam int DP_FRAC_W  = 52;
   localparam logic [11:0] SP_BIAS = 12'h07F;  // 127
   localparam logic [11:0] DP_BIAS = 12'h3FF;  // 1023

   typedef enum logic [2:0] {OP_PACK, OP_UNPACK, OP_STORE, OP_LOAD, OP_FP} op_t;
   typedef enum logic [1:0] {KIND_WORD, KIND_LONG, KIND_BIT} kind_t;

   typedef struct packed {
      logic [3:0] addr;    // Base storage point
      logic [4:0] start;   // First bit point
      logic [3:0] digits;  // Nibble count
      logic [1:0] kind;    // Storage kind
      logic       dbl;     // Double precision
      logic [2:0] op;      // Operation
   } cmd_t;

   typedef struct packed {
      logic              sign;      // 1 means negative
      logic              zero;      // All bits clear
      logic              neg_zero;  // Only top bit set
      logic              invalid;   // Reserved exponent code
      logic signed [11:0] power;    // Unbiased exponent
      logic [51:0]       frac;      // Bits after the leading one
   } fp_info_t;

endpackage

/* verilog/point_mem.sv */
`timescale 1ns/1ps

module point_mem #(
   parameter int W = 16,  // Bits per point
   parameter int D = 16   // Number of points
) (
   input  wire logic                 aclk,     // System clock
   input  wire logic                 we,       // Write strobe
   input  wire logic [$clog2(D)-1:0] waddr,    // Write point
   input  wire logic [W-1:0]         wdata,    // Write value
   input  wire logic [$clog2(D)-1:0] raddr,    // Read point
   output logic      [W-1:0]         rdata_q   // Registered read value
);

   logic [W-1:0] mem [D];  // Storage points, not reset

   // ***********************************************
   // Write port and registered read
   // ***********************************************
   always_ff @(posedge aclk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
      rdata_q <= mem[raddr];  // One cycle of read latency
   end

endmodule

/* verilog/fp_field_decode.sv */
`timescale 1ns/1ps

module fp_field_decode (
   input  wire logic              [63:0] opnd,  // Operand, single in bits 31..0
   input  wire logic                     dbl,   // Double precision select
   output dpf_pkg::fp_info_t             info   // Decoded fields
);
   import dpf_pkg::*;

   // Single precision slices
   wire [SP_EXP_W-1:0]  sp_exp  = opnd[30:23];
   wire                 sp_zero = (opnd[31:0] == 32'h0000_0000);
   wire                 sp_nz   = (opnd[31:0] == 32'h8000_0000);
   wire                 sp_res  = (sp_exp == 8'hFF) || (sp_exp == 8'h00);
   // Double precision slices
   wire [DP_EXP_W-1:0]  dp_exp  = opnd[62:52];
   wire                 dp_zero = (opnd == 64'h0000_0000_0000_0000);
   wire                 dp_nz   = (opnd == 64'h8000_0000_0000_0000);
   wire                 dp_res  = (dp_exp == 11'h7FF) || (dp_exp == 11'h000);

   // ***********************************************
   // Field split and classification
   // ***********************************************
   always_comb
   begin
      if (dbl)
      begin
         info.sign     = opnd[63];
         info.frac     = opnd[DP_FRAC_W-1:0];
         info.power    = $signed({1'b0, dp_exp}) - $signed(DP_BIAS);
         info.zero     = dp_zero;
         info.neg_zero = dp_nz;
         info.invalid  = dp_res && !dp_zero && !dp_nz;
      end
      else
      begin
         info.sign     = opnd[31];
         info.frac     = {29'h0, opnd[SP_FRAC_W-1:0]};
         info.power    = $signed({4'h0, sp_exp}) - $signed(SP_BIAS);
         info.zero     = sp_zero;
         info.neg_zero = sp_nz;
         info.invalid  = sp_res && !sp_zero && !sp_nz;
      end
   end

endmodule

/* verilog/digit_pack_and_float_format.sv */
// Functional notes
// - n digits cover 4n points from start
// - Range follows digit count; eight is full
// - Packed read zero-fills bits above span
// - Unpack updates only points inside span
// - Word storage holds 32 bits in two points
// - Long storage holds 32 bits per point
// - Double-word storage holds 32 bits per point
// - Real: single two words, double four words
// - Real operands never from bit points
// - Sign bit zero positive, one negative
// - Single exponent bias 127, FF/00 reserved
// - Double exponent bias 1023, 7FF/00 reserved
// - Real zero has every bit clear
// - Negative zero gives an operation error
`timescale 1ns/1ps

module digit_pack_and_float_format #(
   parameter int WORD_DEPTH = 16,  // Word points, 16 bits each
   parameter int LONG_DEPTH = 16   // Long or double-word points
) (
   input  wire logic        aclk,          // System clock
   input  wire logic        aresetn,       // Synchronous reset, low active
   input  wire logic [7:0]  s_axi_awaddr,  // Write address
   input  wire logic [2:0]  s_axi_awprot,  // Unused protection
   input  wire logic        s_axi_awvalid, // Write address valid
   output logic             s_axi_awready, // Write address ready
   input  wire logic [31:0] s_axi_wdata,   // Write data
   input  wire logic [3:0]  s_axi_wstrb,   // Byte enables
   input  wire logic        s_axi_wvalid,  // Write data valid
   output logic             s_axi_wready,  // Write data ready
   output logic [1:0]       s_axi_bresp,   // Write response
   output logic             s_axi_bvalid,  // Write response valid
   input  wire logic        s_axi_bready,  // Write response ready
   input  wire logic [7:0]  s_axi_araddr,  // Read address
   input  wire logic [2:0]  s_axi_arprot,  // Unused protection
   input  wire logic        s_axi_arvalid, // Read address valid
   output logic             s_axi_arready, // Read address ready
   output logic [31:0]      s_axi_rdata,   // Read data
   output logic [1:0]       s_axi_rresp,   // Read response
   output logic             s_axi_rvalid,  // Read data valid
   input  wire logic        s_axi_rready,  // Read data ready
   output logic             irq            // Level interrupt
);
   import dpf_pkg::*;

   // ***********************************************
   // Helper functions
   // ***********************************************
   // Ones over the 4n low bits of the span
   function automatic logic [31:0] span_mask(input logic [3:0] d);
      logic [5:0] w;
      w = {d[3:0], 2'b00};
      if (w >= 6'd32)
         span_mask = 32'hFFFF_FFFF;
      else
         span_mask = (32'h0000_0001 << w) - 32'h0000_0001;
   endfunction

   // Byte-lane merge of a bus write
   function automatic logic [31:0] merge_strb(input logic [31:0] o, n, input logic [3:0] s);
      for (int i = 0; i < 4; i++)
         merge_strb[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
   endfunction

   // Points moved per operation
   function automatic logic [2:0] chunk_count(input cmd_t c);
      if (c.kind == KIND_LONG)
         chunk_count = (c.op == OP_FP && c.dbl) ? 3'd2 : 3'd1;
      else
         chunk_count = (c.op == OP_FP && c.dbl) ? 3'd4 : 3'd2;
   endfunction

   typedef enum logic [1:0] {S_IDLE, S_RUN} state_t;

   // ***********************************************
   // State
   // ***********************************************
   state_t       state_q;       // Engine state
   cmd_t         cmd_q;         // Command being run
   logic [2:0]   step_q;        // Point counter
   logic [63:0]  bits_q;        // Bit points 0..63
   logic [31:0]  data_in_q;     // Word source
   logic [31:0]  result_q;      // Packed or loaded word
   logic [63:0]  opnd_q;        // Gathered operand
   fp_info_t     fp_q;          // Last decoded real operand
   logic         err_q;         // Last operation failed
   logic [1:0]   ev_q;          // Sticky events
   logic [1:0]   mask_q;        // Event enables
   logic [7:0]   aw_addr_q;     // Held write address
   logic [31:0]  w_data_q;      // Held write data
   logic [3:0]   w_strb_q;      // Held byte enables

   // ***********************************************
   // Bus decode
   // ***********************************************
   wire wr_fire  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   wire rd_fire  = s_axi_arvalid && s_axi_arready;
   wire wr_cmd   = wr_fire && (aw_addr_q == REG_CMD);
   wire wr_blo   = wr_fire && (aw_addr_q == REG_BITS_LO);
   wire wr_bhi   = wr_fire && (aw_addr_q == REG_BITS_HI);
   wire wr_din   = wr_fire && (aw_addr_q == REG_DATA_IN);
   wire wr_mask  = wr_fire && (aw_addr_q == REG_IRQ_MASK);
   wire rd_stat  = rd_fire && (s_axi_araddr == REG_IRQ_STAT);
   // Software view of CMD; struct keeps the bus field order but packs out the gaps
   wire [31:0] cmd_img = {4'h0, cmd_q[18:15], 3'h0, cmd_q[14:10], 4'h0, cmd_q[9:6], 2'h0, cmd_q[5:0]};
   wire [31:0] cmd_w   = merge_strb(cmd_img, w_data_q, w_strb_q);
   wire cmd_t new_cmd  = {cmd_w[27:24], cmd_w[20:16], cmd_w[11:8], cmd_w[5:0]};

   logic [31:0] rd_val;  // Read mux
   logic        rd_hit;  // Mapped address
   always_comb
   begin
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         REG_CMD:      rd_val = cmd_img;
         REG_STATUS:   rd_val = {30'h0, err_q, state_q != S_IDLE};
         REG_BITS_LO:  rd_val = bits_q[31:0];
         REG_BITS_HI:  rd_val = bits_q[63:32];
         REG_DATA_IN:  rd_val = data_in_q;
         REG_RESULT:   rd_val = result_q;
         REG_FP_INFO:  rd_val = {4'h0, fp_q.power, 12'h0, fp_q.sign, fp_q.invalid,
                                 fp_q.neg_zero, fp_q.zero};
         REG_FRAC_LO:  rd_val = fp_q.frac[31:0];
         REG_FRAC_HI:  rd_val = {12'h0, fp_q.frac[51:32]};
         REG_IRQ_STAT: rd_val = {30'h0, ev_q};
         REG_IRQ_MASK: rd_val = {30'h0, mask_q};
         default:
         begin
            rd_val = 32'h0000_0000;  // Unmapped reads as zero with error
            rd_hit = 1'b0;
         end
      endcase
   end

   // ***********************************************
   // Digit datapath
   // ***********************************************
   wire [31:0] dmask     = span_mask(cmd_q.digits);
   // Lowest point of the span lands in bit 0, rest cleared
   wire [63:0] shifted   = bits_q >> cmd_q.start;
   wire [31:0] packed_v  = shifted[31:0] & dmask;
   wire [63:0] span64    = {32'h0, dmask} << cmd_q.start;
   wire [63:0] ins64     = {32'h0, data_in_q & dmask} << cmd_q.start;
   // Points past the span keep their old state
   wire [63:0] unpacked  = (bits_q & ~span64) | ins64;

   // ***********************************************
   // Storage and operand gathering
   // ***********************************************
   localparam int WA = $clog2(WORD_DEPTH);
   localparam int LA = $clog2(LONG_DEPTH);
   wire        is_long  = (cmd_q.kind == KIND_LONG);
   wire [2:0]  n_chunk  = chunk_count(cmd_q);
   wire        running  = (state_q == S_RUN);
   wire        st_phase = running && (cmd_q.op == OP_STORE) && (step_q < n_chunk);
   wire [WA-1:0] w_addr = WA'(cmd_q.addr) + WA'(step_q);  // Pairs are consecutive
   wire [LA-1:0] l_addr = LA'(cmd_q.addr) + LA'(step_q);
   wire [15:0] w_rd;                        // Word point read
   wire [31:0] l_rd;                        // Long point read
   // Low half of a word pair sits in the lower point
   wire [15:0] w_wr     = step_q[0] ? data_in_q[31:16] : data_in_q[15:0];

   point_mem #(.W(16), .D(WORD_DEPTH)) u_words (
      .aclk    (aclk),
      .we      (st_phase && !is_long),
      .waddr   (w_addr),
      .wdata   (w_wr),
      .raddr   (w_addr),
      .rdata_q (w_rd)
   );

   point_mem #(.W(32), .D(LONG_DEPTH)) u_longs (
      .aclk    (aclk),
      .we      (st_phase && is_long),   // One point holds 32 bits
      .waddr   (l_addr),
      .wdata   (data_in_q),
      .raddr   (l_addr),
      .rdata_q (l_rd)
   );

   // Place the point read last cycle into the gathered operand
   logic [63:0] opnd_nx;
   always_comb
   begin
      opnd_nx = opnd_q;
      if (step_q != 3'd0)
      begin
         if (is_long)
            opnd_nx[32*(step_q-3'd1) +: 32] = l_rd;
         else
            opnd_nx[16*(step_q-3'd1) +: 16] = w_rd;
      end
   end

   fp_info_t fp_dec;  // Fields of the operand now gathered

   fp_field_decode u_fp (
      .opnd (opnd_nx),
      .dbl  (cmd_q.dbl),
      .info (fp_dec)
   );

   // ***********************************************
   // Command checks and completion
   // ***********************************************
   wire dig_bad  = (new_cmd.digits == 4'h0) || (new_cmd.digits > 4'(MAX_DIGITS));
   wire needs_d  = (new_cmd.op == OP_PACK) || (new_cmd.op == OP_UNPACK);
   // Real operands only come from word or typed storage
   wire fp_bit   = (new_cmd.op == OP_FP) && (new_cmd.kind == KIND_BIT);
   wire kind_bad = (new_cmd.op inside {OP_STORE, OP_LOAD})
                   && (new_cmd.kind == KIND_BIT);
   wire op_bad   = (new_cmd.op > OP_FP) || (needs_d && dig_bad) || fp_bit || kind_bad;
   wire start    = wr_cmd && (state_q == S_IDLE);
   wire reject   = start && op_bad;
   wire simple   = (cmd_q.op == OP_PACK) || (cmd_q.op == OP_UNPACK);
   wire fin_xfer = (cmd_q.op == OP_STORE) ? (step_q == n_chunk - 3'd1)
                                          : (step_q == n_chunk);
   wire finish   = running && (simple || fin_xfer);
   wire fp_err   = (cmd_q.op == OP_FP) && (fp_dec.neg_zero || fp_dec.invalid);
   wire [1:0] ev_set = {reject || (finish && fp_err), finish};

   // ***********************************************
   // Engine
   // ***********************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q <= S_IDLE;
         cmd_q   <= '0;
         step_q  <= 3'd0;
         opnd_q  <= 64'h0;
         err_q   <= 1'b0;
      end
      else if (start)
      begin
         cmd_q   <= new_cmd;   // Refused while busy
         step_q  <= 3'd0;
         opnd_q  <= 64'h0;
         err_q   <= op_bad;
         state_q <= op_bad ? S_IDLE : S_RUN;
      end
      else if (running)
      begin
         opnd_q  <= opnd_nx;
         step_q  <= step_q + 3'd1;
         if (finish)
         begin
            state_q <= S_IDLE;
            err_q   <= fp_err;
         end
      end
   end

   // Datapath results
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         result_q <= REG_RST;
         fp_q     <= '0;
      end
      else if (finish)
      begin
         if (cmd_q.op == OP_PACK)
            result_q <= packed_v;
         else if (cmd_q.op == OP_LOAD)
            result_q <= opnd_nx[31:0];
         if (cmd_q.op == OP_FP)
            fp_q     <= fp_dec;
      end
   end

   // Software registers; the engine's unpack wins a clash
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bits_q    <= {REG_RST, REG_RST};
         data_in_q <= REG_RST;
         mask_q    <= EV_NONE;
      end
      else
      begin
         if (finish && cmd_q.op == OP_UNPACK)
            bits_q <= unpacked;
         else if (wr_blo)
            bits_q[31:0]  <= merge_strb(bits_q[31:0], w_data_q, w_strb_q);
         else if (wr_bhi)
            bits_q[63:32] <= merge_strb(bits_q[63:32], w_data_q, w_strb_q);
         if (wr_din)
            data_in_q <= merge_strb(data_in_q, w_data_q, w_strb_q);
         if (wr_mask && w_strb_q[0])
            mask_q <= w_data_q[1:0];
      end
   end

   // ***********************************************
   // Interrupt
   // ***********************************************
   // A new event in the clearing read cycle survives
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ev_q <= EV_NONE;
         irq  <= 1'b0;
      end
      else
      begin
         ev_q <= (rd_stat ? EV_NONE : ev_q) | ev_set;
         irq  <= |(ev_q & mask_q);
      end
   end

   // ***********************************************
   // AXI4-Lite handshakes
   // ***********************************************
   // Address and data are held separately, then written together
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         aw_addr_q     <= 8'h00;
         w_data_q      <= REG_RST;
         w_strb_q      <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_addr_q     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q > REG_IRQ_MASK || aw_addr_q[1:0] != 2'b00)
                            ? 2'b10 : 2'b00;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Single read in flight; data sampled at address acceptance
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= REG_RST;
         s_axi_rresp   <= 2'b00;
      end
      else if (rd_fire)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_val;
         s_axi_rresp   <= rd_hit ? 2'b00 : 2'b10;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule

/* testbench/dpf_properties.sv */
`timescale 1ns/1ps
// *************************
// Register bus checks
// *************************
module dpf_properties (
   input wire logic       aclk,          // Clock
   input wire logic       aresetn,       // Reset, low active
   input wire logic       s_axi_awvalid, // AW valid
   input wire logic       s_axi_awready, // AW ready
   input wire logic       s_axi_wvalid,  // W valid
   input wire logic       s_axi_wready,  // W ready
   input wire logic       s_axi_bvalid,  // B valid
   input wire logic       s_axi_bready,  // B ready
   input wire logic [1:0] s_axi_bresp,   // B code
   input wire logic       s_axi_arvalid, // AR valid
   input wire logic       s_axi_arready, // AR ready
   input wire logic       s_axi_rvalid,  // R valid
   input wire logic       s_axi_rready,  // R ready
   input wire logic       irq            // Interrupt
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Answers stand until taken
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read answer dropped");
   r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   b_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
   // One of each in flight
   aw_wait_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   ar_wait_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answering");
   b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   rst_val_a: assert property (disable iff (1'b0) !aresetn |=> s_axi_awready && s_axi_arready
      && !s_axi_bvalid && !s_axi_rvalid && !irq) else $error("bad reset state");
endmodule
bind digit_pack_and_float_format dpf_properties u_props (.*);

/* testbench/axi_host.sv */
`timescale 1ns/1ps
// *************************
// Register bus master
// *************************
module axi_host (
   input wire logic aclk,    // System clock
   input wire logic aresetn  // Reset, low active
);
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;   // Addresses
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;              // Data
   logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;      // Unused
   logic [3:0]  s_axi_wstrb = 4'hF;                            // Whole words
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;     // Write offers
   logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0;      // Answer accept
   logic        s_axi_arvalid = 1'b0;                          // Read offer
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;     // Slave write side
   logic        s_axi_arready, s_axi_rvalid, irq;              // Slave read side
   logic [1:0]  s_axi_bresp, s_axi_rresp;                      // Answer codes
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic ap = 1'b1, wp = 1'b1;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (ap || wp)
      begin
         @(posedge aclk);
         if (ap && s_axi_awready)
         begin
            ap = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (wp && s_axi_wready)
         begin
            wp = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   digit_pack_and_float_format u_dut (.*);  // Design under test
endmodule

/* testbench/digit_pack_and_float_format_test.sv */
`timescale 1ns/1ps
module digit_pack_and_float_format_test;
   import dpf_pkg::*;
   logic        aclk;      // System clock
   logic        aresetn;   // Reset, low active
   int          err_total; // Mismatches
   int          n_tests;   // Comparisons
   logic [31:0] d;         // Last read data
   logic [1:0]  r;         // Last answer code
   // Single: value, info, mask, error
   logic [31:0] fop [5] = '{32'hC0A0_0000, 32'h0, 32'h8000_0000, 32'h7F80_0001, 32'h0080_0000};
   logic [31:0] fin [5] = '{32'h0002_0008, 32'h1, 32'hA, 32'h4, 32'h0F82_0000};
   logic [31:0] fmk [5] = '{32'hFFFF_FFFF, 32'hF, 32'hA, 32'h4, 32'hFFFF_FFFF};
   logic        fer [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
   axi_host host (.aclk(aclk), .aresetn(aresetn));
   function automatic logic [31:0] cmd(input logic [2:0] op, input logic [1:0] k,
      input logic [3:0] n, input logic [4:0] s, input logic [3:0] a, input logic dbl);
      return {4'h0, a, 3'h0, s, 4'h0, n, 2'h0, k, dbl, op};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask
   task automatic put(input logic [7:0] a, input logic [31:0] v);
      host.wr(a, v, r);
      chk({30'h0, r}, 32'h0);
   endtask
   task automatic get(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      host.rd(a, d, r);
      chk({30'h0, r}, 32'h0);
      chk(d & m, e);
   endtask
   // Start, then poll busy
   task automatic run(input logic [31:0] c);
      put(REG_CMD, c);
      repeat (20)
      begin
         host.rd(REG_STATUS, d, r);
         if (!d[ST_BUSY_BIT]) break;
      end
   endtask
   task automatic pack_test;
      put(REG_BITS_LO, 32'hA5C3_9E71);
      put(REG_BITS_HI, 32'h0000_0F0F);
      run(cmd(OP_PACK, KIND_BIT, 4'h5, 5'h04, 4'h0, 1'b0));
      get(REG_RESULT, 32'h000C_39E7, '1);
      chk({31'h0, host.irq}, 32'h0);
      put(REG_IRQ_MASK, 32'h1);
      repeat (2) @(posedge aclk);
      chk({31'h0, host.irq}, 32'h1);
      run(cmd(OP_PACK, KIND_BIT, 4'h8, 5'h1C, 4'h0, 1'b0));
      get(REG_RESULT, 32'h0000_F0FA, '1);
      get(REG_IRQ_STAT, 32'h1, '1);
      repeat (2) @(posedge aclk);
      chk({31'h0, host.irq}, 32'h0);
      put(REG_BITS_LO, 32'h0);
      put(REG_DATA_IN, 32'hFFFF_FFFF);
      run(cmd(OP_UNPACK, KIND_BIT, 4'h3, 5'h08, 4'h0, 1'b0));
      get(REG_BITS_LO, 32'h000F_FF00, '1);
      get(REG_BITS_HI, 32'h0000_0F0F, '1);
   endtask
   // Neighbour stores show points per value
   task automatic mem_test;
      for (int k = 0; k < 2; k++)
      begin
         put(REG_DATA_IN, 32'h1234_5678);
         run(cmd(OP_STORE, k[1:0], 4'h0, 5'h00, 4'h2, 1'b0));
         put(REG_DATA_IN, 32'h0000_AAAA);
         run(cmd(OP_STORE, k[1:0], 4'h0, 5'h00, 4'h3, 1'b0));
         run(cmd(OP_LOAD, k[1:0], 4'h0, 5'h00, 4'h2, 1'b0));
         get(REG_RESULT, k ? 32'h1234_5678 : 32'hAAAA_5678, '1);
      end
   endtask
   task automatic fp_test;
      host.rd(REG_IRQ_STAT, d, r);
      for (int i = 0; i < 5; i++)
      begin
         put(REG_DATA_IN, fop[i]);
         run(cmd(OP_STORE, KIND_WORD, 4'h0, 5'h00, 4'h4, 1'b0));
         run(cmd(OP_FP, KIND_WORD, 4'h0, 5'h00, 4'h4, 1'b0));
         get(REG_FP_INFO, fin[i], fmk[i]);
         get(REG_IRQ_STAT, {30'h0, fer[i], 1'b0}, 32'h2);
      end
      get(REG_FRAC_LO, 32'h0000_0000, '1);
      put(REG_DATA_IN, 32'h0000_0001);
      run(cmd(OP_STORE, KIND_LONG, 4'h0, 5'h00, 4'h0, 1'b0));
      put(REG_DATA_IN, 32'hFFE8_0000);
      run(cmd(OP_STORE, KIND_LONG, 4'h0, 5'h00, 4'h1, 1'b0));
      run(cmd(OP_FP, KIND_LONG, 4'h0, 5'h00, 4'h0, 1'b1));
      get(REG_FP_INFO, 32'h03FF_0008, '1);
      get(REG_FRAC_HI, 32'h0008_0000, '1);
      get(REG_FRAC_LO, 32'h0000_0001, '1);
      host.rd(REG_IRQ_STAT, d, r);
      run(cmd(OP_FP, KIND_BIT, 4'h0, 5'h00, 4'h0, 1'b0));
      get(REG_IRQ_STAT, 32'h2, '1);
      host.wr(8'h3C, 32'h1, r);
      chk({30'h0, r}, 32'h2);
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // Watchdog, about 25000 cycles
   initial
   begin
      #200000;
      err_total++;
      end_sim;
   end
   initial
   begin
      err_total = 0;
      n_tests = 0;
      aresetn = 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      pack_test;
      mem_test;
      fp_test;
      end_sim;
   end
endmodule
